// ===== rtl/ldo_setting_defs.svh
`ifndef LDO_SETTING_DEFS_SVH
`define LDO_SETTING_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define LDO_A_VSEL_IDX 8'h50
`define LDO_A_CTRL_IDX 8'h51
`define LDO_B_VSEL_IDX 8'h54
`define LDO_B_CTRL_IDX 8'h55
`define LDO_C_VSEL_IDX 8'h60
`define LDO_C_CTRL_IDX 8'h61
`define LDO_D_VSEL_IDX 8'h64
`define LDO_D_CTRL_IDX 8'h65
`define FAULT_STATUS_IDX 8'h70
`define FAULT_MASK_IDX 8'h71

// Control register field positions.
`define CTRL_ENABLE_BIT 7
`define CTRL_DISCHARGE_BIT 6
`define CTRL_SAVER_BIT 5
`define CTRL_DELAY_HI 4
`define CTRL_DELAY_LO 2
`define CTRL_ALLOW_BIT 1
`define CTRL_POK_BIT 0

// Voltage-selection register field positions.
`define VSEL_CODE_HI 5
`define VSEL_CODE_LO 0

// Reset values.
`define CTRL_RESET 8'h00
`define VSEL_RESET 8'h00
`define FAULT_MASK_RESET 4'h0

// Bus answers.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== rtl/ldo_setting_pkg.sv
`default_nettype none
package ldo_setting_pkg;

    // Settings that one regulator output takes from software.
    typedef struct packed {
        logic enable;
        logic shutdown_discharge;
        logic quiescent_saver;
        logic [2:0] turn_on_delay;
        logic fault_irq_allow;
        logic [5:0] target_level_code;
    } ldo_cfg_s;

    typedef logic [1:0] axi_resp_t;

endpackage
`default_nettype wire

// ===== rtl/ldo_setting_regs.sv
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ldo_setting_defs.svh"

// Function
// - Control bit 0 reads 1 while the output is above its power-OK level.
// - Control bit 7 enables the regulator when written 1, disables when 0.
// - Control bit 6 enables active output discharge during shutdown.
// - Control bit 5 selects low-quiescent-current mode when set.
// - Control bits 4:2 hold the read/write start-up delay code.
// - Control bit 1 set lets regulator faults raise the interrupt.
// - Voltage-selection bits 7:6 are reserved, read zero, ignore writes.
// - Voltage-selection low bits hold the read/write target level code.
module ldo_setting_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output ldo_setting_pkg::axi_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output ldo_setting_pkg::axi_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] power_ok_in,
    input wire logic [3:0] fault_in,
    output ldo_setting_pkg::ldo_cfg_s [3:0] ldo_cfg,
    output logic irq
);
    import ldo_setting_pkg::*;

    localparam int NCH = 4;
    localparam logic [NCH-1:0][7:0] VSEL_IDX = {`LDO_D_VSEL_IDX,
        `LDO_C_VSEL_IDX, `LDO_B_VSEL_IDX, `LDO_A_VSEL_IDX};
    localparam logic [NCH-1:0][7:0] CTRL_IDX = {`LDO_D_CTRL_IDX,
        `LDO_C_CTRL_IDX, `LDO_B_CTRL_IDX, `LDO_A_CTRL_IDX};
    localparam logic [7:0] CTRL_RST = `CTRL_RESET;
    localparam logic [7:0] VSEL_RST = `VSEL_RESET;

    // The register index is taken from address bits 9:2.
    if (ADDR_W < 10)
    begin : g_addr_check
        $error("ADDR_W must be at least 10 to reach every register");
    end

    ldo_cfg_s [NCH-1:0] cfg_q;
    logic [NCH-1:0] pok_meta_q;
    logic [NCH-1:0] pok_q;
    logic [NCH-1:0] fault_meta_q;
    logic [NCH-1:0] fault_q;
    logic [NCH-1:0] fault_prev_q;
    logic [NCH-1:0] fault_edge;
    logic [NCH-1:0] status_q;
    logic [NCH-1:0] mask_q;
    logic irq_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    axi_resp_t bresp_q;
    logic arready_q;
    logic rvalid_q;
    axi_resp_t rresp_q;
    logic [31:0] rdata_q;
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic wr_hit;

    // True when an index names a register of this block.
    function automatic logic is_mapped(input logic [7:0] idx);
        logic hit;
        hit = (idx == `FAULT_STATUS_IDX) || (idx == `FAULT_MASK_IDX);
        for (int k = 0; k < NCH; k++)
        begin
            hit = hit || (idx == VSEL_IDX[k]) || (idx == CTRL_IDX[k]);
        end
        return hit;
    endfunction

    // Address and data are taken together, so a write lands in one edge.
    assign wr_en = awready_q && s_axi_awvalid && s_axi_wvalid;
    assign rd_en = arready_q && s_axi_arvalid;
    assign wr_idx = s_axi_awaddr[9:2];
    assign rd_idx = s_axi_araddr[9:2];
    assign wr_hit = is_mapped(wr_idx);

    // Write channel: both readies rise for a cycle once both halves wait.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end
        else
        begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            if (s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q)
            begin
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
            if (wr_en)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read mux; reserved and unimplemented bits read as zero.
    always_comb
    begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
        if (rd_idx == `FAULT_STATUS_IDX)
        begin
            rd_byte = {4'h0, status_q};
            rd_hit = 1'b1;
        end
        if (rd_idx == `FAULT_MASK_IDX)
        begin
            rd_byte = {4'h0, mask_q};
            rd_hit = 1'b1;
        end
        for (int k = 0; k < NCH; k++)
        begin
            if (rd_idx == VSEL_IDX[k])
            begin
                rd_byte = {2'h0, cfg_q[k].target_level_code};
                rd_hit = 1'b1;
            end
            if (rd_idx == CTRL_IDX[k])
            begin
                rd_byte = {cfg_q[k].enable, cfg_q[k].shutdown_discharge,
                    cfg_q[k].quiescent_saver, cfg_q[k].turn_on_delay,
                    cfg_q[k].fault_irq_allow, pok_q[k]};
                rd_hit = 1'b1;
            end
        end
    end

    // Read channel: data is captured at the address edge and held.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= `RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            arready_q <= 1'b0;
            if (s_axi_arvalid && !arready_q && !rvalid_q)
            begin
                arready_q <= 1'b1;
            end
            if (rd_en)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h00_0000, rd_byte};
                rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (rvalid_q && s_axi_rready)
            begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Comparator and fault pins are asynchronous, so both pass two stages.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pok_meta_q <= '0;
            pok_q <= '0;
            fault_meta_q <= '0;
            fault_q <= '0;
            fault_prev_q <= '0;
        end
        else
        begin
            pok_meta_q <= power_ok_in;
            pok_q <= pok_meta_q;
            fault_meta_q <= fault_in;
            fault_q <= fault_meta_q;
            fault_prev_q <= fault_q;
        end
    end

    assign fault_edge = fault_q & ~fault_prev_q;

    // Per-output settings and sticky fault flags.
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                cfg_q[i] <= ldo_cfg_s'({CTRL_RST[7:1], VSEL_RST[5:0]});
            end
            else if (wr_en && s_axi_wstrb[0])
            begin
                if (wr_idx == VSEL_IDX[i])
                begin
                    cfg_q[i].target_level_code <=
                        s_axi_wdata[`VSEL_CODE_HI:`VSEL_CODE_LO];
                end
                if (wr_idx == CTRL_IDX[i])
                begin
                    cfg_q[i].enable <= s_axi_wdata[`CTRL_ENABLE_BIT];
                    cfg_q[i].shutdown_discharge <=
                        s_axi_wdata[`CTRL_DISCHARGE_BIT];
                    cfg_q[i].quiescent_saver <=
                        s_axi_wdata[`CTRL_SAVER_BIT];
                    cfg_q[i].turn_on_delay <=
                        s_axi_wdata[`CTRL_DELAY_HI:`CTRL_DELAY_LO];
                    cfg_q[i].fault_irq_allow <=
                        s_axi_wdata[`CTRL_ALLOW_BIT];
                end
            end
        end

        // A new fault beats a write-one-to-clear in the same cycle.
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                status_q[i] <= 1'b0;
            end
            else if (fault_edge[i] && cfg_q[i].fault_irq_allow)
            begin
                status_q[i] <= 1'b1;
            end
            else if (wr_en && s_axi_wstrb[0]
                && wr_idx == `FAULT_STATUS_IDX && s_axi_wdata[i])
            begin
                status_q[i] <= 1'b0;
            end
        end
    end

    // Mask register and the registered interrupt level.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mask_q <= `FAULT_MASK_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            if (wr_en && s_axi_wstrb[0] && wr_idx == `FAULT_MASK_IDX)
            begin
                mask_q <= s_axi_wdata[NCH-1:0];
            end
            irq_q <= |(status_q & mask_q);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign ldo_cfg = cfg_q;
    assign irq = irq_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // A control write to output A with lane 0 enabled.
    sequence ctrl_a_write_s;
        wr_en && s_axi_wstrb[0] && wr_idx == `LDO_A_CTRL_IDX;
    endsequence

    // A read of output A's control register being taken.
    sequence ctrl_a_read_s;
        rd_en && rd_idx == `LDO_A_CTRL_IDX;
    endsequence

    pok_readback_a: assert property (ctrl_a_read_s |=>
        s_axi_rvalid && s_axi_rdata[0] == $past(pok_q[0]))
        else $error("power-OK bit read back wrong");

    enable_write_a: assert property (ctrl_a_write_s |=>
        ldo_cfg[0].enable == $past(s_axi_wdata[7]))
        else $error("enable bit not taken from write");

    discharge_write_a: assert property (ctrl_a_write_s |=>
        ldo_cfg[0].shutdown_discharge == $past(s_axi_wdata[6]))
        else $error("discharge bit not taken from write");

    saver_write_a: assert property (ctrl_a_write_s |=>
        ldo_cfg[0].quiescent_saver == $past(s_axi_wdata[5]))
        else $error("quiescent mode bit not taken from write");

    delay_write_a: assert property (ctrl_a_write_s |=>
        ldo_cfg[0].turn_on_delay == $past(s_axi_wdata[4:2]))
        else $error("start-up delay field not taken from write");

    fault_gate_a: assert property (fault_edge[0] && !status_q[0]
        |=> status_q[0] == $past(cfg_q[0].fault_irq_allow))
        else $error("fault flag ignores the allow bit");

    reserved_read_a: assert property (
        rd_en && rd_idx == `LDO_B_VSEL_IDX
        |=> s_axi_rvalid && s_axi_rdata[7:6] == 2'h0)
        else $error("reserved voltage bits read nonzero");

    level_code_a: assert property (wr_en && s_axi_wstrb[0]
        && wr_idx == `LDO_B_VSEL_IDX
        |=> ldo_cfg[1].target_level_code == $past(s_axi_wdata[5:0]))
        else $error("target level code not taken from write");

    pok_source_a: assert property (ctrl_a_write_s |=>
        pok_q[0] == $past(power_ok_in[0], 2))
        else $error("power-OK bit disturbed by a write");

    irq_level_a: assert property (##1 irq ==
        |($past(status_q) & $past(mask_q)))
        else $error("interrupt does not follow masked status");

    write_resp_a: assert property (wr_en |=> s_axi_bvalid
        && s_axi_bresp == ($past(wr_hit) ? `RESP_OKAY : `RESP_SLVERR))
        else $error("write response missing or wrong");

endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ldo_setting_defs.svh"

module tb;
    import ldo_setting_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [3:0] wstrb, pok, fault;
    axi_resp_t bresp, rresp;
    ldo_cfg_s [3:0] cfg;
    logic [7:0] mdl [0:255];
    logic [7:0] vidx [4] = '{`LDO_A_VSEL_IDX, `LDO_B_VSEL_IDX,
        `LDO_C_VSEL_IDX, `LDO_D_VSEL_IDX};
    logic [31:0] got_c, exp_c;
    int n_mismatch, n_checks;

    ldo_setting_regs #(.ADDR_W(12)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .power_ok_in(pok),
        .fault_in(fault), .ldo_cfg(cfg), .irq(irq));

    // Free-running bus clock at 25 MHz.
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Settings that output i should carry, built from the shadow copy.
    function automatic ldo_cfg_s exp_cfg(input int i);
        logic [7:0] c;
        c = mdl[vidx[i] + 8'h1];
        return {c[7:1], mdl[vidx[i]][5:0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h",
                $time, what, got, exp);
        end
    endtask

    // One write; the shadow copy keeps only the bits the slave stores.
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input axi_resp_t er);
        @(posedge aclk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "write resp");
        // Refused writes and writes with lane 0 off store nothing.
        if (er == `RESP_OKAY && wstrb[0])
        begin
            case (idx)
                `FAULT_STATUS_IDX: mdl[idx] = mdl[idx] & ~d;
                `FAULT_MASK_IDX: mdl[idx] = d & 8'h0f;
                default: mdl[idx] = d & (idx[0] ? 8'hfe : 8'h3f);
            endcase
        end
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                      input axi_resp_t er);
        @(posedge aclk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, {24'h0, exp}, "read data");
        chk({30'h0, rresp}, {30'h0, er}, "read resp");
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever.
    initial
    begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        wrap_up();
    end

    // Main sequence.
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'h1;
        pok = 4'h0;
        fault = 4'h0;
        seed = 32'd91302;
        for (int k = 0; k < 256; k++)
            mdl[k] = 8'h00;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // Every voltage-selection, control and fault status register reads zero out of reset.
        for (int i = 0; i < 4; i++)
        begin
            rd(vidx[i], 8'h00, `RESP_OKAY);
            rd(vidx[i] + 8'h1, 8'h00, `RESP_OKAY);
        end
        rd(`FAULT_STATUS_IDX, 8'h00, `RESP_OKAY);
        // Random codes, including writes of ones to the read-only bits.
        for (int p = 0; p < 4; p++)
            for (int i = 0; i < 4; i++)
            begin
                seed = lfsr(lfsr(lfsr(seed)));
                pok <= seed[11:8];
                wr(vidx[i], seed[7:0] | 8'hc0, `RESP_OKAY);
                wr(vidx[i] + 8'h1, seed[23:16], `RESP_OKAY);
                rd(vidx[i], mdl[vidx[i]], `RESP_OKAY);
                rd(vidx[i] + 8'h1, {mdl[vidx[i] + 8'h1][7:1], pok[i]},
                    `RESP_OKAY);
                got_c = {19'h0, cfg[i]};
                exp_c = {19'h0, exp_cfg(i)};
                chk(got_c, exp_c, "cfg");
            end
        // Holes in the map answer with an error and change nothing.
        wr(8'h52, 8'hff, `RESP_SLVERR);
        rd(8'h52, 8'h00, `RESP_SLVERR);
        // Lane 0 strobe low: the write is answered but nothing is stored.
        wstrb <= 4'h0;
        wr(`LDO_B_CTRL_IDX, 8'hff, `RESP_OKAY);
        wstrb <= 4'h1;
        rd(`LDO_B_CTRL_IDX, {mdl[`LDO_B_CTRL_IDX][7:1], pok[1]},
            `RESP_OKAY);
        // A fault with the interrupt allowed and unmasked raises irq.
        wr(`LDO_A_CTRL_IDX, 8'h02, `RESP_OKAY);
        wr(`FAULT_MASK_IDX, 8'h01, `RESP_OKAY);
        rd(`FAULT_MASK_IDX, mdl[`FAULT_MASK_IDX], `RESP_OKAY);
        fault <= 4'h1;
        repeat (8) @(posedge aclk);
        chk({31'h0, irq}, 32'h1, "irq set");
        rd(`FAULT_STATUS_IDX, 8'h01, `RESP_OKAY);
        mdl[`FAULT_STATUS_IDX] = 8'h01;
        wr(`FAULT_STATUS_IDX, 8'h01, `RESP_OKAY);
        fault <= 4'h0;
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0, "irq clear");
        rd(`FAULT_STATUS_IDX, 8'h00, `RESP_OKAY);
        // Masked: the event is recorded but irq stays low.
        wr(`FAULT_MASK_IDX, 8'h00, `RESP_OKAY);
        fault <= 4'h1;
        repeat (8) @(posedge aclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        rd(`FAULT_STATUS_IDX, 8'h01, `RESP_OKAY);
        mdl[`FAULT_STATUS_IDX] = 8'h01;
        wr(`FAULT_STATUS_IDX, 8'h01, `RESP_OKAY);
        fault <= 4'h0;
        // Allow bit cleared: the fault is not recorded at all.
        wr(`LDO_A_CTRL_IDX, 8'h00, `RESP_OKAY);
        wr(`FAULT_MASK_IDX, 8'h01, `RESP_OKAY);
        fault <= 4'h1;
        repeat (8) @(posedge aclk);
        chk({31'h0, irq}, 32'h0, "irq not allowed");
        rd(`FAULT_STATUS_IDX, 8'h00, `RESP_OKAY);
        wrap_up();
    end
endmodule
`default_nettype wire
